// ===== hdl/intc_pkg.sv
package intc_pkg;
	localparam int          NUM_SRC        = 19;
	localparam int          SMALL_SRC      = 11;
	localparam int          IDX_W          = 5;
	localparam int          LVL_W          = 2;
	localparam int          VEC_W          = 16;
	localparam int          NUM_PINS       = 4;
	localparam logic [15:0] VEC_RESET      = 16'h0000;
	localparam logic [15:0] VEC_FIRST      = 16'h0004;
	localparam logic [15:0] VEC_SMALL_LAST = 16'h0018;
	localparam logic [15:0] VEC_LARGE_LAST = 16'h0028;
	localparam logic [15:0] VEC_BREAK      = 16'h007E;
	localparam logic [7:0]  OPCODE_TRAP    = 8'hFF;
	localparam logic [1:0]  LVL_LOWEST     = 2'h3;
	// default priority indices
	localparam int          SRC_WDTI       = 0;
	localparam int          SRC_PIN0       = 1;
	localparam int          SRC_PIN1       = 2;
	localparam int          SRC_SHARED_TX  = 3;
	localparam int          SRC_RX         = 4;
	localparam int          SRC_RXERR      = 5;
	localparam int          SRC_T1H        = 6;
	localparam int          SRC_T0         = 7;
	localparam int          SRC_T1         = 8;
	localparam int          SRC_AD         = 9;
	localparam int          SRC_KEY        = 10;
	localparam int          SRC_PIN2       = 11;
	localparam int          SRC_PIN3       = 12;
	localparam int          SRC_T3H        = 13;
	localparam int          SRC_I2C        = 14;
	localparam int          SRC_T2         = 15;
	localparam int          SRC_T3         = 16;
	localparam int          SRC_IT         = 17;
	localparam int          SRC_CMP        = 18;
	// watchdog interval point: 3/4 of overflow count, plus 3/4 low-speed period
	localparam int          WDT_NUM        = 3;
	localparam int          WDT_SHIFT      = 2;
	localparam int          FIL_QUARTERS   = 3;
	localparam int          SYS_PERIOD_NS  = 10;
endpackage : intc_pkg

// ===== hdl/intc_core.sv
`timescale 1ns/1ps
module intc_core #(
	parameter int LARGE_VARIANT = 1,
	parameter int WDT_W         = 16,
	parameter int FIL_PERIOD_NS = 66667
) (
	input  wire logic                                        i_sys_clk,
	input  wire logic                                        i_rst_b,
	input  wire logic [WDT_W-1:0]                            i_wdt_count,
	input  wire logic [WDT_W-1:0]                            i_wdt_ovf_count,
	input  wire logic                                        i_serial_tx_end_irq,
	input  wire logic                                        i_clocked_serial0_irq,
	input  wire logic                                        i_simple_i2c0_irq,
	input  wire logic                                        i_serial_rx_end_irq,
	input  wire logic                                        i_clocked_serial1_irq,
	input  wire logic                                        i_serial_rx_error_irq,
	input  wire logic                                        i_timer_ch1_high_irq,
	input  wire logic                                        i_timer_ch0_irq,
	input  wire logic                                        i_timer_ch1_irq,
	input  wire logic                                        i_conversion_end_irq,
	input  wire logic                                        i_timer_ch3_high_irq,
	input  wire logic                                        i_i2c_unit_irq,
	input  wire logic                                        i_timer_ch2_irq,
	input  wire logic                                        i_timer_ch3_irq,
	input  wire logic                                        i_interval_timer_irq,
	input  wire logic                                        i_comparator_edge_irq,
	input  wire logic [intc_pkg::NUM_PINS-1:0]               i_pin_edge_irq,
	input  wire logic                                        i_key_return_irq_b,
	input  wire logic [intc_pkg::NUM_PINS-1:0]               i_rise_en,
	input  wire logic [intc_pkg::NUM_PINS-1:0]               i_fall_en,
	input  wire logic [intc_pkg::NUM_SRC-1:0]                i_mask,
	input  wire logic [intc_pkg::LVL_W*intc_pkg::NUM_SRC-1:0] i_level,
	input  wire logic                                        i_ie,
	input  wire logic [intc_pkg::LVL_W-1:0]                  i_isp,
	input  wire logic                                        i_int_ack,
	input  wire logic                                        i_break_instruction,
	input  wire logic                                        i_opcode_valid,
	input  wire logic [7:0]                                  i_opcode,
	input  wire logic                                        i_debug_active,
	input  wire logic                                        i_reset_pin_b,
	input  wire logic                                        i_selectable_power_on_reset,
	input  wire logic                                        i_watchdog_overflow_reset,
	output logic                                             o_int_req,
	output logic                                             o_int_soft,
	output logic [intc_pkg::VEC_W-1:0]                       o_int_vector,
	output logic [intc_pkg::LVL_W-1:0]                       o_int_level,
	output logic                                             o_standby_release,
	output logic                                             o_reset_req,
	output logic [intc_pkg::VEC_W-1:0]                       o_reset_vector,
	output logic [intc_pkg::NUM_SRC-1:0]                     o_pending
);
	localparam int N       = intc_pkg::NUM_SRC;
	localparam int ACT_N   = (LARGE_VARIANT != 0) ? intc_pkg::NUM_SRC : intc_pkg::SMALL_SRC;
	localparam int DLY_NS  = (FIL_PERIOD_NS * intc_pkg::FIL_QUARTERS + 3) / 4;
	localparam int DLY_CYC = (DLY_NS + intc_pkg::SYS_PERIOD_NS - 1) / intc_pkg::SYS_PERIOD_NS;
	localparam int DLY_W   = $clog2(DLY_CYC + 2);
	localparam int SYNC_N  = intc_pkg::NUM_PINS + 2;

	typedef logic [intc_pkg::IDX_W-1:0] idx_t;

	// found, level, index of the best candidate
	function automatic logic [intc_pkg::IDX_W+intc_pkg::LVL_W:0] pick
		(input logic [N-1:0] cand, input logic [intc_pkg::LVL_W*N-1:0] lvl);
		logic                      found;
		logic [intc_pkg::LVL_W-1:0] best_l;
		idx_t                      best_i;
		found  = 1'b0;
		best_l = intc_pkg::LVL_LOWEST;
		best_i = '0;
		for (int k = N - 1; k >= 0; k--)
		begin
			// walking down with <= lets the lower index win a tie
			if (cand[k] && (!found || lvl[k*intc_pkg::LVL_W +: intc_pkg::LVL_W] <= best_l))
			begin
				found  = 1'b1;
				best_l = lvl[k*intc_pkg::LVL_W +: intc_pkg::LVL_W];
				best_i = idx_t'(k);
			end
		end
		return {found, best_l, best_i};
	endfunction : pick

	function automatic logic [intc_pkg::VEC_W-1:0] vec_of(input idx_t idx);
		return intc_pkg::VEC_FIRST + {10'h000, idx, 1'b0};
	endfunction : vec_of

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	logic [SYNC_N-1:0] sync1_q;
	logic [SYNC_N-1:0] sync2_q;
	logic [SYNC_N-1:0] sync3_q;
	logic [intc_pkg::NUM_PINS-1:0] pin_evt;
	logic              key_evt;

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sync1_q <= {SYNC_N{1'b1}};
			sync2_q <= {SYNC_N{1'b1}};
			sync3_q <= {SYNC_N{1'b1}};
		end
		else
		begin
			sync1_q <= {i_reset_pin_b, i_key_return_irq_b, i_pin_edge_irq};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign pin_evt = (sync2_q[intc_pkg::NUM_PINS-1:0] & ~sync3_q[intc_pkg::NUM_PINS-1:0] & i_rise_en)
		| (~sync2_q[intc_pkg::NUM_PINS-1:0] & sync3_q[intc_pkg::NUM_PINS-1:0] & i_fall_en);
	// key return lines are pulled up; a key press pulls low
	assign key_evt = ~sync2_q[intc_pkg::NUM_PINS] & sync3_q[intc_pkg::NUM_PINS];

	////////////////////////////////////////////////////////////////////////////
	// watchdog interval point
	logic [WDT_W+1:0] wdt_thr;
	logic             wdt_match_q;
	logic [DLY_W-1:0] wdt_dly_q;
	logic             wdt_evt;

	assign wdt_thr = ({2'b00, i_wdt_ovf_count} * (WDT_W+2)'(intc_pkg::WDT_NUM)) >> intc_pkg::WDT_SHIFT;

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wdt_match_q <= 1'b0;
			wdt_dly_q   <= '0;
		end
		else
		begin
			wdt_match_q <= ({2'b00, i_wdt_count} == wdt_thr);
			// the extra 3/4 low-speed period is timed in system clocks
			if (({2'b00, i_wdt_count} == wdt_thr) && !wdt_match_q && wdt_dly_q == '0)
				wdt_dly_q <= DLY_W'(DLY_CYC);
			else if (wdt_dly_q != '0)
				wdt_dly_q <= wdt_dly_q - DLY_W'(1);
		end
	end

	assign wdt_evt = (wdt_dly_q == DLY_W'(1));

	////////////////////////////////////////////////////////////////////////////
	// request flags
	logic [N-1:0] raw_req;
	logic [N-1:0] act_src;
	logic [N-1:0] flag_q;
	logic [N-1:0] cand;
	logic [intc_pkg::IDX_W+intc_pkg::LVL_W:0] best;
	logic         ack_mask;
	idx_t         ack_idx_q;

	always_comb
	begin
		raw_req                         = '0;
		raw_req[intc_pkg::SRC_WDTI]     = wdt_evt;
		raw_req[intc_pkg::SRC_PIN0]     = pin_evt[0];
		raw_req[intc_pkg::SRC_PIN1]     = pin_evt[1];
		raw_req[intc_pkg::SRC_SHARED_TX] = i_serial_tx_end_irq | i_clocked_serial0_irq
			| i_simple_i2c0_irq;
		raw_req[intc_pkg::SRC_RX]       = i_serial_rx_end_irq
			| (i_clocked_serial1_irq && LARGE_VARIANT != 0);
		raw_req[intc_pkg::SRC_RXERR]    = i_serial_rx_error_irq;
		raw_req[intc_pkg::SRC_T1H]      = i_timer_ch1_high_irq;
		raw_req[intc_pkg::SRC_T0]       = i_timer_ch0_irq;
		raw_req[intc_pkg::SRC_T1]       = i_timer_ch1_irq;
		raw_req[intc_pkg::SRC_AD]       = i_conversion_end_irq;
		raw_req[intc_pkg::SRC_KEY]      = key_evt;
		raw_req[intc_pkg::SRC_PIN2]     = pin_evt[2];
		raw_req[intc_pkg::SRC_PIN3]     = pin_evt[3];
		raw_req[intc_pkg::SRC_T3H]      = i_timer_ch3_high_irq;
		raw_req[intc_pkg::SRC_I2C]      = i_i2c_unit_irq;
		raw_req[intc_pkg::SRC_T2]       = i_timer_ch2_irq;
		raw_req[intc_pkg::SRC_T3]       = i_timer_ch3_irq;
		raw_req[intc_pkg::SRC_IT]       = i_interval_timer_irq;
		raw_req[intc_pkg::SRC_CMP]      = i_comparator_edge_irq;
	end

	// only a maskable acknowledge clears a flag
	assign ack_mask = i_int_ack && o_int_req && !o_int_soft;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_flag
			assign act_src[g] = (g < ACT_N);
			always_ff @(posedge i_sys_clk or negedge i_rst_b)
			begin
				if (!i_rst_b)
					flag_q[g] <= 1'b0;
				else if (raw_req[g] && act_src[g])
					flag_q[g] <= 1'b1;
				else if (ack_mask && ack_idx_q == idx_t'(g))
					flag_q[g] <= 1'b0;
			end
		end
	endgenerate

	assign cand = flag_q & ~i_mask & act_src;
	assign best = pick(cand, i_level);

	////////////////////////////////////////////////////////////////////////////
	// software break
	logic break_pend_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			break_pend_q <= 1'b0;
		else if (i_break_instruction)
			break_pend_q <= 1'b1;
		else if (i_int_ack && o_int_req && o_int_soft)
			break_pend_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// presentation to the core
	logic [intc_pkg::LVL_W-1:0] best_l;
	idx_t                       best_i;
	logic                       best_ok;

	assign best_l  = best[intc_pkg::IDX_W +: intc_pkg::LVL_W];
	assign best_i  = best[intc_pkg::IDX_W-1:0];
	assign best_ok = best[intc_pkg::IDX_W+intc_pkg::LVL_W] && i_ie && (best_l <= i_isp);

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_int_req    <= 1'b0;
			o_int_soft   <= 1'b0;
			o_int_vector <= intc_pkg::VEC_RESET;
			o_int_level  <= intc_pkg::LVL_LOWEST;
			ack_idx_q    <= '0;
		end
		else if (i_int_ack)
		begin
			// the flags settle this edge; offer again one cycle later
			o_int_req <= 1'b0;
		end
		else if (break_pend_q)
		begin
			o_int_req    <= 1'b1;
			o_int_soft   <= 1'b1;
			o_int_vector <= intc_pkg::VEC_BREAK;
		end
		else
		begin
			o_int_req    <= best_ok;
			o_int_soft   <= 1'b0;
			o_int_vector <= vec_of(best_i);
			o_int_level  <= best_l;
			ack_idx_q    <= best_i;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_standby_release <= 1'b0;
			o_pending         <= '0;
		end
		else
		begin
			// wakes the core whatever the global enable says
			o_standby_release <= |cand;
			o_pending         <= flag_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reset sources
	logic trap;

	assign trap = i_opcode_valid && (i_opcode == intc_pkg::OPCODE_TRAP) && !i_debug_active;

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_reset_req    <= 1'b0;
			o_reset_vector <= intc_pkg::VEC_RESET;
		end
		else
		begin
			o_reset_req    <= !sync2_q[SYNC_N-1] || i_selectable_power_on_reset
				|| i_watchdog_overflow_reset || trap;
			o_reset_vector <= intc_pkg::VEC_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	chk_break_taken: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		break_pend_q && !i_int_ack |=> o_int_req && o_int_soft
			&& o_int_vector == intc_pkg::VEC_BREAK)
		else $error("break not offered at its vector");

	chk_break_no_level: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_break_instruction && !i_ie ##1 !i_int_ack |=> o_int_req && o_int_soft)
		else $error("break blocked by enable or level");

	chk_vec_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_int_req && !o_int_soft |-> o_int_vector >= intc_pkg::VEC_FIRST
			&& o_int_vector <= ((LARGE_VARIANT != 0) ? intc_pkg::VEC_LARGE_LAST
			: intc_pkg::VEC_SMALL_LAST) && !o_int_vector[0])
		else $error("maskable vector outside table");

	chk_level_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(o_int_req) && !o_int_soft |-> $past(i_ie) && o_int_level <= $past(i_isp))
		else $error("request offered above in-service level");

	chk_flag_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		flag_q[intc_pkg::SRC_T0] && !(ack_mask && ack_idx_q == idx_t'(intc_pkg::SRC_T0))
			|=> flag_q[intc_pkg::SRC_T0])
		else $error("flag dropped without acknowledge");

	chk_shared_src: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clocked_serial0_irq || i_simple_i2c0_irq |=> flag_q[intc_pkg::SRC_SHARED_TX])
		else $error("shared source flag not set");

	chk_timer_split: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_timer_ch1_high_irq ##1 !i_mask[intc_pkg::SRC_T1H] && (o_pending == '0)
			&& !break_pend_q && i_ie && !i_int_ack && i_level[2*intc_pkg::SRC_T1H +: 2] <= i_isp
			|=> o_int_req && o_int_vector == 16'h0010)
		else $error("high byte timer vector wrong");

	chk_standby_wake: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		|(flag_q & ~i_mask & act_src) |=> o_standby_release)
		else $error("standby release missing");

	chk_trap_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_opcode_valid && i_opcode == intc_pkg::OPCODE_TRAP && !i_debug_active
			|=> o_reset_req && o_reset_vector == intc_pkg::VEC_RESET)
		else $error("illegal opcode did not reset");

endmodule : intc_core

// ===== testbench/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_int_req,
	input  wire logic        i_int_soft,
	input  wire logic [15:0] i_int_vector,
	input  wire logic        i_hold,
	input  wire logic [3:0]  i_delay,
	output logic             o_int_ack,
	output logic [15:0]      o_taken_vec,
	output logic             o_taken_soft,
	output logic [7:0]       o_taken_cnt
);
	logic [3:0] wait_q;

	////////////////////////////////////////////////////////////////////////////////
	// the vector is latched at the edge that samples the acknowledge, since the
	// offer may still move to a better request while the core is slow to answer
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_int_ack    <= 1'b0;
			wait_q       <= 4'h0;
			o_taken_vec  <= 16'h0000;
			o_taken_soft <= 1'b0;
			o_taken_cnt  <= 8'h00;
		end
		else if (o_int_ack)
		begin
			o_int_ack    <= 1'b0;
			wait_q       <= 4'h0;
			o_taken_vec  <= i_int_vector;
			o_taken_soft <= i_int_soft;
			o_taken_cnt  <= o_taken_cnt + 8'h01;
		end
		else if (i_int_req && !i_hold)
		begin
			if (wait_q >= i_delay)
				o_int_ack <= 1'b1;
			else
				wait_q <= wait_q + 4'h1;
		end
	end
endmodule : cpu_core_model

// ===== testbench/interrupt_source_priority_vectoring_test.sv
`timescale 1ns/1ps
module interrupt_source_priority_vectoring_test;
	logic        sys_clk;
	logic        rst_b;
	logic [18:0] ev;
	logic [3:0]  alt;
	logic [18:0] mask;
	logic [37:0] lvl;
	logic [1:0]  isp;
	logic [7:0]  opc;
	logic [3:0]  dly;
	logic [3:0]  rise_en, fall_en;
	logic        ie, hold, opv, dbg, sel_por, wdtr, pin_b;
	logic        int_ack, int_req, int_soft, standby, reset_req, taken_soft;
	logic [15:0] int_vec, reset_vec, taken_vec;
	logic [1:0]  int_lvl;
	logic [18:0] pending;
	logic [7:0]  taken_cnt;
	int          fails;
	int          checks;

	intc_core #(.LARGE_VARIANT(1), .WDT_W(16), .FIL_PERIOD_NS(40)) u_intc_core (
		.i_sys_clk(sys_clk), .i_rst_b(rst_b),
		// the interval point for an overflow count of 10H is 0CH
		.i_wdt_count(ev[0] ? 16'h000C : 16'h0000), .i_wdt_ovf_count(16'h0010),
		.i_serial_tx_end_irq(ev[3]), .i_clocked_serial0_irq(alt[0]),
		.i_simple_i2c0_irq(alt[1]), .i_serial_rx_end_irq(ev[4]),
		.i_clocked_serial1_irq(alt[2]), .i_serial_rx_error_irq(ev[5]),
		.i_timer_ch1_high_irq(ev[6]), .i_timer_ch0_irq(ev[7]), .i_timer_ch1_irq(ev[8]),
		.i_conversion_end_irq(ev[9]), .i_timer_ch3_high_irq(ev[13]),
		.i_i2c_unit_irq(ev[14]), .i_timer_ch2_irq(ev[15]), .i_timer_ch3_irq(ev[16]),
		.i_interval_timer_irq(ev[17]), .i_comparator_edge_irq(ev[18]),
		.i_pin_edge_irq({ev[12], ev[11], ev[2], ev[1]}), .i_key_return_irq_b(~ev[10]),
		.i_rise_en(rise_en), .i_fall_en(fall_en), .i_mask(mask), .i_level(lvl), .i_ie(ie),
		.i_isp(isp), .i_int_ack(int_ack), .i_break_instruction(alt[3]),
		.i_opcode_valid(opv), .i_opcode(opc), .i_debug_active(dbg), .i_reset_pin_b(pin_b),
		.i_selectable_power_on_reset(sel_por), .i_watchdog_overflow_reset(wdtr),
		.o_int_req(int_req), .o_int_soft(int_soft), .o_int_vector(int_vec),
		.o_int_level(int_lvl), .o_standby_release(standby), .o_reset_req(reset_req),
		.o_reset_vector(reset_vec), .o_pending(pending));

	cpu_core_model u_cpu_core_model (
		.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_int_req(int_req), .i_int_soft(int_soft),
		.i_int_vector(int_vec), .i_hold(hold), .i_delay(dly), .o_int_ack(int_ack),
		.o_taken_vec(taken_vec), .o_taken_soft(taken_soft), .o_taken_cnt(taken_cnt));

	////////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one-cycle pulse; pins see the rising edge, key return its falling edge
	task automatic fire(input logic [18:0] s, input logic [3:0] a);
		@(negedge sys_clk);
		ev  = s;
		alt = a;
		@(negedge sys_clk);
		ev  = 19'h00000;
		alt = 4'h0;
	endtask : fire

	task automatic take(input string what, input logic [15:0] exp);
		int         n;
		logic [7:0] c0;
		c0 = taken_cnt;
		for (n = 0; n < 40 && taken_cnt == c0; n++)
			@(negedge sys_clk);
		check(what, exp, (n < 40) ? taken_vec : 16'hFFFF);
	endtask : take

	task automatic settle(input logic [15:0] exp_req, input logic [15:0] exp_sb);
		repeat (3) @(negedge sys_clk);
		check("int_req", exp_req, {15'h0000, int_req});
		check("standby", exp_sb, {15'h0000, standby});
	endtask : settle

	task automatic rst_src(input int k, input logic d, input logic [7:0] op, input logic exp);
		@(negedge sys_clk);
		dbg   = d;
		opv   = (k == 0);
		opc   = op;
		sel_por = (k == 1);
		wdtr  = (k == 2);
		pin_b = (k != 3);
		// the pin passes a two-stage synchroniser before the register
		repeat ((k == 3) ? 3 : 1) @(negedge sys_clk);
		check("reset_req", {15'h0000, exp}, {15'h0000, reset_req});
		check("reset_vector", 16'h0000, reset_vec);
		{opv, sel_por, wdtr, dbg, pin_b} = 5'h01;
		repeat (4) @(negedge sys_clk);
	endtask : rst_src

	////////////////////////////////////////////////////////////////////////////////
	task automatic s_vectors;
		for (int i = 0; i < 19; i++)
		begin
			fire(19'h00001 << i, 4'h0);
			take("vector", 16'h0004 + 16'(2 * i));
		end
		fire(19'h00000, 4'h1);
		take("shared_cs0", 16'h000A);
		fire(19'h00000, 4'h2);
		take("shared_i2c", 16'h000A);
		fire(19'h00000, 4'h4);
		take("shared_cs1", 16'h000C);
		// falling edge only: the rising half of the pulse must not add a second request
		{rise_en, fall_en} = 8'h0F;
		fire(19'h00002, 4'h0);
		take("fall_edge", 16'h0006);
		settle(16'h0000, 16'h0000);
		{rise_en, fall_en} = 8'hF0;
	endtask : s_vectors

	task automatic s_order;
		hold = 1'b1;
		fire(19'h002A0, 4'h0);
		repeat (2) @(negedge sys_clk);
		check("pending", 16'h02A0, pending[15:0]);
		hold = 1'b0;
		take("order_first", 16'h000E);
		take("order_second", 16'h0012);
		take("order_third", 16'h0016);
		for (int l = 0; l < 4; l++)
		begin
			hold        = 1'b1;
			lvl[37:36]  = l[1:0];
			fire(19'h40000, 4'h0);
			repeat (3) @(negedge sys_clk);
			check("offer_level", {14'h0000, l[1:0]}, {14'h0000, int_lvl});
			hold = 1'b0;
			take("vector", 16'h0028);
		end
		lvl        = '1;
		lvl[19:18] = 2'h0;
		hold       = 1'b1;
		dly        = 4'h3;
		fire(19'h00220, 4'h0);
		hold = 1'b0;
		take("level_wins", 16'h0016);
		take("level_after", 16'h000E);
		dly = 4'h0;
	endtask : s_order

	task automatic s_mask;
		mask[7] = 1'b1;
		fire(19'h00080, 4'h0);
		settle(16'h0000, 16'h0000);
		check("pending", 16'h0001, {15'h0000, pending[7]});
		ie      = 1'b0;
		mask[7] = 1'b0;
		settle(16'h0000, 16'h0001);
		ie = 1'b1;
		take("unmasked", 16'h0012);
	endtask : s_mask

	task automatic s_nest;
		isp        = 2'h1;
		lvl[17:16] = 2'h2;
		fire(19'h00100, 4'h0);
		settle(16'h0000, 16'h0001);
		fire(19'h00200, 4'h0);
		take("nested", 16'h0016);
		isp = 2'h3;
		take("resumed", 16'h0014);
	endtask : s_nest

	task automatic s_break;
		ie   = 1'b0;
		mask = '1;
		isp  = 2'h0;
		fire(19'h00000, 4'h8);
		take("break", 16'h007E);
		check("break_soft", 16'h0001, {15'h0000, taken_soft});
		{ie, mask, isp, hold} = {1'b1, 19'h00000, 2'h3, 1'b1};
		fire(19'h00200, 4'h8);
		hold = 1'b0;
		take("break_first", 16'h007E);
		take("maskable_after", 16'h0016);
	endtask : s_break

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		results();
	end

	initial
	begin
		{ev, alt, mask, lvl, isp, opc, dly} = {19'h00000, 4'h0, 19'h00000, 38'h3FFFFFFFFF,
			2'h3, 8'h00, 4'h0};
		{ie, hold, opv, dbg, sel_por, wdtr, pin_b} = 7'h41;
		{rise_en, fall_en} = 8'hF0;
		{fails, checks} = {32'h0, 32'h0};
		rst_b = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		s_vectors();
		s_order();
		s_mask();
		s_nest();
		s_break();
		rst_src(0, 1'b0, 8'hFF, 1'b1);
		rst_src(0, 1'b1, 8'hFF, 1'b0);
		rst_src(0, 1'b0, 8'hFE, 1'b0);
		rst_src(1, 1'b0, 8'h00, 1'b1);
		rst_src(2, 1'b0, 8'h00, 1'b1);
		rst_src(3, 1'b0, 8'h00, 1'b1);
		results();
	end
endmodule : interrupt_source_priority_vectoring_test
